// ==== core/hcws_pkg.sv ====
// Notes on behaviour
// - Function 1 after-run hit sets the timer flag and interrupt; reset or read clears it.
// - The timer flag is produced only in function 1 and stays 0 under any other function.
// - Strap report bit7 gives the pre-regulator topology: 0 buck-boost, 1 buck only.
// - Straps are captured at power-on reset and again on each exit from low-power off.
// - Bit5: reference regulator with external transistor (0) or internal pass device (1).
// - Response bit4 gives the reference regulator voltage, 0 for 3.3 V and 1 for 5.0 V.
// - Response bit3 gives the auxiliary regulator voltage, 0 for 5.0 V and 1 for 3.3 V.
// - Response bit1 gives the deep fail-safe strap, 0 disabled and 1 enabled.
// - Response bit0 gives the debug strap, 0 normal and 1 debug.
// - Wake sources are read with bit15 low, 001001 in bits 14:9; eight flags return in 7:0.
// - Each monitored pin sets its own wake flag when it caused a wake-up.
// - A wake flag in bits 7:1 holds 1 once set and returns to 0 on reset or on a read of the register.
// - The automatic wake flag sits in bit2 of the wake source response.
// - The timer wake flag sits in bit1 and clears on read or reset.
// - Transceiver wake flag in bit0; cleared by reset or a read of the transceiver flags.
package hcws_pkg;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] CMD_LEN = 5'h07;
    localparam logic [6:0] CMD_TIMER = 7'h06;
    localparam logic [6:0] CMD_STRAP = 7'h08;
    localparam logic [6:0] CMD_WAKE = 7'h09;
    localparam logic [2:0] TIMER_FUNC1 = 3'h0;
    localparam logic STRAP_BIT2_VAL = 1'b1;
    localparam logic STRAP_BIT6_VAL = 1'b0;
    localparam logic [7:0] STRAP_RESET = 8'h04;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int STRAP_PREREG_POS = 7;
    localparam int STRAP_RSVD_POS = 6;
    localparam int STRAP_REF_XTR_POS = 5;
    localparam int STRAP_REF_V_POS = 4;
    localparam int STRAP_AUX_V_POS = 3;
    localparam int STRAP_ONE_POS = 2;
    localparam int STRAP_DFS_POS = 1;
    localparam int STRAP_DBG_POS = 0;
    localparam int WAKE_AUTO_POS = 2;
    localparam int WAKE_TIMER_POS = 1;
    localparam int WAKE_PHY_POS = 0;
endpackage

// ==== core/hcws_frame_if.sv ====
interface hcws_frame_if;
    logic [7:0] status_hi;
    logic [6:0] cmd;
    logic cmd_valid;
    logic [7:0] rsp;
    logic frame_end;
    logic frame_ok;

    modport shifter (input status_hi, input rsp, output cmd, output cmd_valid,
        output frame_end, output frame_ok);
    modport core (output status_hi, output rsp, input cmd, input cmd_valid,
        input frame_end, input frame_ok);
endinterface

// ==== core/hcws_flag.sv ====
module hcws_flag #(
    parameter int W = 8
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [W-1:0] set, // event pulses
    input wire logic [W-1:0] clr, // clear mask
    output logic [W-1:0] q // sticky flags
);
    // set wins over clear in the same cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= (q & ~clr) | set;
    end
endmodule

// ==== core/hcws_spi_slave.sv ====
module hcws_spi_slave (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic sclk, // spi clock, sampled
    input wire logic cs_n, // spi chip select, active low
    input wire logic mosi, // spi data in
    output logic miso, // spi data out
    output logic miso_oe, // miso output enable
    hcws_frame_if.shifter fr // frame events to the core
);
    localparam int FRAME_BITS_M1 = hcws_pkg::FRAME_BITS - 1;

    logic sclk_prev_reg;
    logic cs_prev_reg;
    logic [4:0] bit_cnt_reg;
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic load_reg;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;

    assign rise = sclk & ~sclk_prev_reg & ~cs_n;
    assign fall = ~sclk & sclk_prev_reg & ~cs_n;
    assign cs_fall = ~cs_n & cs_prev_reg;
    assign cs_rise = cs_n & ~cs_prev_reg;
    assign miso = tx_reg[FRAME_BITS_M1];

    // ****************************************
    // edge history
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
            miso_oe <= 1'b0;
        end
        else
        begin
            sclk_prev_reg <= sclk;
            cs_prev_reg <= cs_n;
            miso_oe <= ~cs_n;
        end
    end

    // ****************************************
    // receive side
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_cnt_reg <= 5'h00;
            rx_reg <= 16'h0000;
            fr.cmd <= 7'h00;
            fr.cmd_valid <= 1'b0;
        end
        else
        begin
            fr.cmd_valid <= 1'b0;
            if (cs_fall)
                bit_cnt_reg <= 5'h00;
            else if (rise)
            begin
                rx_reg <= {rx_reg[14:0], mosi};
                if (bit_cnt_reg != 5'h1f)
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (bit_cnt_reg == hcws_pkg::CMD_LEN - 5'h01)
                begin
                    fr.cmd <= {rx_reg[5:0], mosi};
                    fr.cmd_valid <= 1'b1;
                end
            end
        end
    end

    // full-length frame with read bit low and all data bits zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fr.frame_end <= 1'b0;
            fr.frame_ok <= 1'b0;
        end
        else
        begin
            fr.frame_end <= cs_rise;
            fr.frame_ok <= cs_rise && bit_cnt_reg == hcws_pkg::FRAME_LEN
                && !rx_reg[15] && rx_reg[8:0] == 9'h000;
        end
    end

    // ****************************************
    // transmit side
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_reg <= 16'h0000;
            load_reg <= 1'b0;
        end
        else
        begin
            load_reg <= fr.cmd_valid;
            if (cs_fall)
                tx_reg <= {fr.status_hi, 8'h00};
            else if (fall)
                tx_reg <= {tx_reg[14:0], 1'b0};
            else if (load_reg)
                tx_reg[13:6] <= fr.rsp;
        end
    end
endmodule

// ==== core/hcws_top.sv ====
module hcws_top (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic sclk, // spi clock
    input wire logic cs_n, // spi chip select, active low
    input wire logic mosi, // spi data in
    output logic miso, // spi data out
    output logic miso_oe, // miso output enable
    input wire logic [7:0] global_status, // global status for bits 15:8
    input wire logic low_power_off_state, // high while in low-power off
    input wire logic strap_prereg_buck_only, // pre-regulator strap
    input wire logic strap_ref_internal, // reference regulator pass device strap
    input wire logic strap_ref_5v0, // reference regulator voltage strap
    input wire logic strap_aux_3v3, // auxiliary regulator voltage strap
    input wire logic strap_deep_failsafe, // deep fail-safe strap
    input wire logic strap_debug, // debug strap
    input wire logic [2:0] timer_function, // selected timer function
    input wire logic timer_after_run_hit, // pulse, counter reached after-run value
    input wire logic [6:0] timer_status, // timer register bits 7:1
    input wire logic [4:0] pin_wake_evt, // pulses, pins 5,4,3,2,0
    input wire logic auto_wake_evt, // pulse, automatic wake-up
    input wire logic timer_wake_evt, // pulse, timer wake-up
    input wire logic phy_wake_evt, // pulse, can or lin wake-up
    input wire logic phy_flags_read, // pulse, transceiver flags were read
    output logic timer_irq // timer interrupt request
);
    hcws_frame_if fr ();

    logic [7:0] hardware_strap_report_reg;
    logic [7:0] hardware_strap_report_next;
    logic capture_req_reg;
    logic low_power_off_state_prev_reg;
    logic [7:0] rsp_reg;
    logic [7:0] wake_snap_reg;
    logic [6:0] last_cmd_reg;
    logic timer_snap_reg;
    logic [7:0] wakeup_cause_flags;
    logic [7:0] wake_set;
    logic [7:0] wake_clr;
    logic timer_after_run_irq_flag;
    logic timer_set;
    logic timer_clr;
    logic read_done;

    assign fr.status_hi = global_status;
    assign fr.rsp = rsp_reg;
    assign read_done = fr.frame_end & fr.frame_ok;

    hcws_spi_slave u_spi (
        .clk(clk),
        .rstn(rstn),
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .miso(miso),
        .miso_oe(miso_oe),
        .fr(fr.shifter)
    );

    // ****************************************
    // strap capture
    // ****************************************
    always_comb
    begin
        hardware_strap_report_next = 8'h00;
        hardware_strap_report_next[hcws_pkg::STRAP_PREREG_POS] = strap_prereg_buck_only;
        hardware_strap_report_next[hcws_pkg::STRAP_RSVD_POS] = hcws_pkg::STRAP_BIT6_VAL;
        hardware_strap_report_next[hcws_pkg::STRAP_REF_XTR_POS] = strap_ref_internal;
        hardware_strap_report_next[hcws_pkg::STRAP_REF_V_POS] = strap_ref_5v0;
        hardware_strap_report_next[hcws_pkg::STRAP_AUX_V_POS] = strap_aux_3v3;
        hardware_strap_report_next[hcws_pkg::STRAP_ONE_POS] = hcws_pkg::STRAP_BIT2_VAL;
        hardware_strap_report_next[hcws_pkg::STRAP_DFS_POS] = strap_deep_failsafe;
        hardware_strap_report_next[hcws_pkg::STRAP_DBG_POS] = strap_debug;
    end

    // capture once after reset release and on each exit from low-power off
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            capture_req_reg <= 1'b1;
            low_power_off_state_prev_reg <= 1'b0;
            hardware_strap_report_reg <= hcws_pkg::STRAP_RESET;
        end
        else
        begin
            low_power_off_state_prev_reg <= low_power_off_state;
            capture_req_reg <= low_power_off_state_prev_reg & ~low_power_off_state;
            if (capture_req_reg)
                hardware_strap_report_reg <= hardware_strap_report_next;
        end
    end

    // ****************************************
    // wake-up source flags
    // ****************************************
    assign wake_set = {pin_wake_evt, auto_wake_evt,
        timer_wake_evt, phy_wake_evt};

    always_comb
    begin
        wake_clr = 8'h00;
        if (read_done && last_cmd_reg == hcws_pkg::CMD_WAKE)
            wake_clr = wake_snap_reg;
        wake_clr[hcws_pkg::WAKE_PHY_POS] = phy_flags_read;
    end

    hcws_flag #(.W(8)) u_wake (
        .clk(clk),
        .rstn(rstn),
        .set(wake_set),
        .clr(wake_clr),
        .q(wakeup_cause_flags)
    );

    // ****************************************
    // timer after-run flag
    // ****************************************
    assign timer_set = timer_after_run_hit && timer_function == hcws_pkg::TIMER_FUNC1;
    assign timer_clr = (timer_function != hcws_pkg::TIMER_FUNC1)
        || (read_done && last_cmd_reg == hcws_pkg::CMD_TIMER && timer_snap_reg);

    hcws_flag #(.W(1)) u_timer (
        .clk(clk),
        .rstn(rstn),
        .set(timer_set),
        .clr(timer_clr),
        .q(timer_after_run_irq_flag)
    );

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            timer_irq <= 1'b0;
        else
            timer_irq <= timer_after_run_irq_flag;
    end

    // ****************************************
    // response selection
    // ****************************************
    // only what was shifted out gets cleared at frame end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rsp_reg <= 8'h00;
            wake_snap_reg <= hcws_pkg::FLAGS_RESET;
            timer_snap_reg <= 1'b0;
            last_cmd_reg <= 7'h00;
        end
        else if (fr.cmd_valid)
        begin
            last_cmd_reg <= fr.cmd;
            wake_snap_reg <= hcws_pkg::FLAGS_RESET;
            timer_snap_reg <= 1'b0;
            case (fr.cmd)
                hcws_pkg::CMD_STRAP:
                    rsp_reg <= hardware_strap_report_reg;
                hcws_pkg::CMD_WAKE:
                begin
                    rsp_reg <= wakeup_cause_flags;
                    wake_snap_reg <= wakeup_cause_flags;
                    wake_snap_reg[hcws_pkg::WAKE_PHY_POS] <= 1'b0;
                end
                hcws_pkg::CMD_TIMER:
                begin
                    rsp_reg <= {timer_status, timer_after_run_irq_flag};
                    timer_snap_reg <= timer_after_run_irq_flag;
                end
                default:
                    rsp_reg <= 8'h00;
            endcase
        end
    end
endmodule

// ==== dv/hcws_top_props.sv ====
// ****
// checker
// ****
module hcws_top_props (
    input wire logic clk, // clock
    input wire logic rstn, // reset, active low
    input wire logic cs_n, // chip select
    input wire logic miso, // data out
    input wire logic miso_oe, // data out enable
    input wire logic [7:0] global_status, // status
    input wire logic [2:0] timer_function, // timer function
    input wire logic timer_after_run_hit, // timer hit
    input wire logic timer_irq // timer irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_irq_off_func: assert property (
        (timer_function != 3'h0) [*2] |=> !timer_irq) else $error("irq outside fn1");
    chk_irq_set_hit: assert property (
        timer_after_run_hit && timer_function == 3'h0 ##1 (timer_function == 3'h0) [*2]
        |-> timer_irq) else $error("irq not set");
    chk_irq_hold_idle: assert property (
        (cs_n && timer_function == 3'h0) [*8] ##0 timer_irq |=> timer_irq)
        else $error("irq lost");
    chk_irq_rise_cause: assert property (
        $rose(timer_irq) |-> $past(timer_after_run_hit, 2)) else $error("irq no cause");
    chk_oe_frame_start: assert property ($fell(cs_n) |=> miso_oe) else $error("oe late");
    chk_oe_idle_low: assert property (cs_n [*2] |-> !miso_oe) else $error("oe idle");
    chk_miso_idle_low: assert property (cs_n [*3] |-> !miso) else $error("miso idle");
    chk_miso_first_bit: assert property (
        $fell(cs_n) ##0 $stable(global_status) |-> ##4 (miso == global_status[7]))
        else $error("first bit");
endmodule

bind hcws_top hcws_top_props hcws_top_props_inst (.clk(clk), .rstn(rstn), .cs_n(cs_n),
    .miso(miso), .miso_oe(miso_oe), .global_status(global_status),
    .timer_function(timer_function), .timer_after_run_hit(timer_after_run_hit),
    .timer_irq(timer_irq));

// ==== dv/hcws_host.sv ====
// ****
// spi master model, mode 0
// ****
module hcws_host (
    input wire logic clk, // clock
    input wire logic miso, // device data
    output logic sclk, // spi clock, still between frames
    output logic cs_n, // chip select
    output logic mosi // host data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // miso is taken just before each sclk rise
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi = w[i];
            repeat (4) @(negedge clk);
            r[i] = miso;
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        mosi = ~mosi;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ==== dv/hcws_top_tb.sv ====
module hcws_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic k; logic [7:0] s; logic [7:0] e;} hcws_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic lpo = 1'b0;
    logic hit = 1'b0;
    logic phy_rd = 1'b0;
    logic [7:0] gs = 8'h5a;
    logic [7:0] st = 8'h00;
    logic [7:0] ev = 8'h00;
    logic [2:0] func = 3'h0;
    logic sclk, cs_n, mosi, miso, miso_oe, irq;
    logic [15:0] r;
    int bad_count = 0;
    int n_compared = 0;
    wire miso_w = miso_oe ? miso : 1'bz;
    // k 0: straps at report positions, k 1: events at flag positions
    hcws_row_t rows [10] = '{'{1'b0, 8'h00, 8'h04}, '{1'b0, 8'hff, 8'hbf},
        '{1'b0, 8'h89, 8'h8d}, '{1'b0, 8'h32, 8'h36}, '{1'b1, 8'hf8, 8'hf8},
        '{1'b1, 8'h50, 8'h50}, '{1'b1, 8'h28, 8'h28},
        '{1'b1, 8'h06, 8'h06}, '{1'b1, 8'h01, 8'h01}, '{1'b1, 8'h00, 8'h00}};
    always #2.5 clk = ~clk;
    hcws_top hcws_top_inst (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .global_status(gs), .low_power_off_state(lpo),
        .strap_prereg_buck_only(st[7]), .strap_ref_internal(st[5]), .strap_ref_5v0(st[4]),
        .strap_aux_3v3(st[3]), .strap_deep_failsafe(st[1]), .strap_debug(st[0]),
        .timer_function(func), .timer_after_run_hit(hit), .timer_status(gs[6:0]),
        .pin_wake_evt(ev[7:3]), .auto_wake_evt(ev[2]), .timer_wake_evt(ev[1]),
        .phy_wake_evt(ev[0]), .phy_flags_read(phy_rd), .timer_irq(irq));
    hcws_host hcws_host_inst (.clk(clk), .miso(miso_w), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
    task automatic test_done();
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [6:0] c, input logic [7:0] e);
        hcws_host_inst.xfer({c, 9'h000}, r);
        chk("status", gs, r[15:8]);
        chk("data", e, r[7:0]);
    endtask
    task automatic pulse(input logic [7:0] e, input logic h);
        @(negedge clk);
        ev = e;
        hit = h;
        @(negedge clk);
        ev = 8'h00;
        hit = 1'b0;
    endtask
    task automatic leave_off();
        lpo = 1'b1;
        repeat (4) @(negedge clk);
        lpo = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    initial
    begin
        #100us;
        bad_count++;
        test_done();
    end
    initial
    begin
        repeat (2) @(negedge clk);
        chk("irq_rst", 8'h00, {7'h00, irq});
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        foreach (rows[i])
        begin
            if (rows[i].k == 1'b0)
            begin
                st = rows[i].s;
                leave_off();
                rd(hcws_pkg::CMD_STRAP, rows[i].e);
            end
            else
            begin
                pulse(rows[i].s, 1'b0);
                rd(hcws_pkg::CMD_WAKE, rows[i].e);
                rd(hcws_pkg::CMD_WAKE, rows[i].e & 8'h01);
                phy_rd = 1'b1;
                @(negedge clk);
                phy_rd = 1'b0;
            end
        end
        // straps alone do not refresh the report
        st = 8'h00;
        repeat (4) @(negedge clk);
        rd(hcws_pkg::CMD_STRAP, 8'h36);
        leave_off();
        rd(hcws_pkg::CMD_STRAP, 8'h04);
        // frame with bit15 set must not clear flags
        pulse(8'h04, 1'b0);
        hcws_host_inst.xfer({hcws_pkg::CMD_WAKE | 7'h40, 9'h000}, r);
        // frame with nonzero trailing bits must not clear flags either
        hcws_host_inst.xfer({hcws_pkg::CMD_WAKE, 9'h001}, r);
        chk("odd_frame", 8'h04, r[7:0]);
        rd(hcws_pkg::CMD_WAKE, 8'h04);
        for (int f = 7; f >= 0; f--)
        begin
            func = 3'(f);
            pulse(8'h00, 1'b1);
            repeat (3) @(negedge clk);
            chk("irq", {7'h00, f == 0}, {7'h00, irq});
        end
        // leaving function 1 drops a set flag
        func = 3'h1;
        repeat (3) @(negedge clk);
        chk("irq_off", 8'h00, {7'h00, irq});
        func = 3'h0;
        pulse(8'h00, 1'b1);
        repeat (3) @(negedge clk);
        rd(hcws_pkg::CMD_TIMER, {gs[6:0], 1'b1});
        chk("irq_clr", 8'h00, {7'h00, irq});
        rd(hcws_pkg::CMD_TIMER, {gs[6:0], 1'b0});
        pulse(8'hf8, 1'b0);
        rstn = 1'b0;
        st = 8'h89;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        gs = 8'ha5;
        repeat (4) @(negedge clk);
        rd(hcws_pkg::CMD_WAKE, 8'h00);
        rd(hcws_pkg::CMD_STRAP, 8'h8d);
        test_done();
    end
endmodule
